// ### bench/udt_pin_model.sv
`timescale 1ns/1ps
// Both pins idle high, as a pulled-up port line would.
module udt_pin_model (
  // Clock.
  input wire logic clk,
  // Requests from the bench.
  input wire logic cnt_req,
  input wire logic trg_req,
  input wire logic trg_low,
  // Pins.
  output logic count_input_pin,
  output logic trigger_pin
);
  initial begin
    count_input_pin = 1'b1;
    trigger_pin = 1'b1;
  end
  always @(posedge clk) begin
    count_input_pin <= ~cnt_req;
    trigger_pin <= ~(trg_req | trg_low);
  end
endmodule

// ### bench/updown_timer_capture_reload_tb.sv
`timescale 1ns/1ps
module updown_timer_capture_reload_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_d = 1'b0;
  logic cnt_req = 1'b0;
  logic trg_req = 1'b0;
  logic trg_low = 1'b0;
  logic [7:0] rdata;
  logic count_input_pin, trigger_pin, baud_tick, irq;
  logic [7:0] exp_q[$];
  int errors = 0;
  int samples_checked = 0;
  integer seed = 32'h16f0;
  logic [31:0] rv;
  always #5 clk = ~clk;
  udt_timer dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .count_input_pin(count_input_pin), .trigger_pin(trigger_pin), .baud_tick(baud_tick), .irq(irq));
  udt_pin_model model (.clk(clk), .cnt_req(cnt_req), .trg_req(trg_req), .trg_low(trg_low),
    .count_input_pin(count_input_pin), .trigger_pin(trigger_pin));
  task automatic check(input string n, input logic [7:0] e, input logic [7:0] s);
    samples_checked++;
    if (s !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, s);
      errors++;
    end
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Read data stand only in the cycle after the strobe, so they are taken there.
  always @(posedge clk) begin
    rd_d <= rd;
    if (rd_d) begin
      check("rdata", exp_q.pop_front(), rdata);
    end
  end
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic pulse(input logic trg);
    trg_req <= trg;
    cnt_req <= ~trg;
    repeat (2) @(posedge clk);
    trg_req <= 1'b0;
    cnt_req <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd_reg(udt_pkg::ADDR_CONTROL, 8'h00);
    rd_reg(4'hA, 8'h00);
    rv = $random(seed);
    wr_reg(udt_pkg::ADDR_RELOAD_LOW, rv[7:0]);
    rd_reg(udt_pkg::ADDR_RELOAD_LOW, rv[7:0]);
    wr_reg(udt_pkg::ADDR_RELOAD_LOW, 8'h00);
    wr_reg(udt_pkg::ADDR_RELOAD_HIGH, 8'h12);
    wr_reg(udt_pkg::ADDR_COUNT_LOW, 8'hFF);
    wr_reg(udt_pkg::ADDR_COUNT_HIGH, 8'hFF);
    wr_reg(udt_pkg::ADDR_CONTROL, 8'h04);
    repeat (20) @(posedge clk);
    rd_reg(udt_pkg::ADDR_COUNT_HIGH, 8'h12);
    rd_reg(udt_pkg::ADDR_IRQ_STATUS, 8'h01);
    wr_reg(udt_pkg::ADDR_IRQ_MASK, 8'h01);
    check("irq", 8'h01, {7'h00, irq});
    wr_reg(udt_pkg::ADDR_IRQ_STATUS, 8'h01);
    check("irq", 8'h00, {7'h00, irq});
    wr_reg(udt_pkg::ADDR_CONTROL, 8'h00);
    wr_reg(udt_pkg::ADDR_COUNT_LOW, 8'hFE);
    wr_reg(udt_pkg::ADDR_COUNT_HIGH, 8'hFF);
    wr_reg(udt_pkg::ADDR_CONTROL, 8'h1C);
    for (int i = 0; i < 40 && baud_tick !== 1'b1; i++) @(negedge clk);
    if (baud_tick !== 1'b1) begin
      errors++;
      complete_run();
    end
    @(posedge clk);
    pulse(1'b1);
    rd_reg(udt_pkg::ADDR_IRQ_STATUS, 8'h02);
    wr_reg(udt_pkg::ADDR_CONTROL, 8'h00);
    wr_reg(udt_pkg::ADDR_IRQ_STATUS, 8'h03);
    wr_reg(udt_pkg::ADDR_COUNT_LOW, 8'h3C);
    wr_reg(udt_pkg::ADDR_COUNT_HIGH, 8'h5A);
    wr_reg(udt_pkg::ADDR_CONTROL, 8'h0F);
    pulse(1'b1);
    rd_reg(udt_pkg::ADDR_RELOAD_LOW, 8'h3C);
    rd_reg(udt_pkg::ADDR_RELOAD_HIGH, 8'h5A);
    repeat (3) pulse(1'b0);
    rd_reg(udt_pkg::ADDR_COUNT_LOW, 8'h3F);
    wr_reg(udt_pkg::ADDR_CONTROL, 8'h00);
    wr_reg(udt_pkg::ADDR_MODE, 8'h01);
    wr_reg(udt_pkg::ADDR_COUNT_LOW, 8'h05);
    wr_reg(udt_pkg::ADDR_COUNT_HIGH, 8'h00);
    trg_low <= 1'b1;
    wr_reg(udt_pkg::ADDR_CONTROL, 8'h0E);
    repeat (2) pulse(1'b0);
    rd_reg(udt_pkg::ADDR_COUNT_LOW, 8'h03);
    wr_reg(udt_pkg::ADDR_CONTROL, 8'h00);
    wr_reg(udt_pkg::ADDR_RELOAD_LOW, 8'h02);
    wr_reg(udt_pkg::ADDR_RELOAD_HIGH, 8'h00);
    wr_reg(udt_pkg::ADDR_CONTROL, 8'h0E);
    repeat (2) pulse(1'b0);
    check("irq", 8'h01, {7'h00, irq});
    rd_reg(udt_pkg::ADDR_COUNT_HIGH, 8'hFF);
    trg_low <= 1'b0;
    pulse(1'b0);
    rd_reg(udt_pkg::ADDR_COUNT_LOW, 8'h02);
    wr_reg(udt_pkg::ADDR_CONTROL, 8'h00);
    wr_reg(udt_pkg::ADDR_MODE, 8'h00);
    wr_reg(udt_pkg::ADDR_COUNT_LOW, 8'h40);
    wr_reg(udt_pkg::ADDR_COUNT_HIGH, 8'h33);
    wr_reg(udt_pkg::ADDR_CONTROL, 8'h0E);
    pulse(1'b1);
    rd_reg(udt_pkg::ADDR_COUNT_HIGH, 8'h00);
    rd_reg(udt_pkg::ADDR_IRQ_STATUS, 8'h02);
    wr_reg(udt_pkg::ADDR_CONTROL, 8'h00);
    wr_reg(udt_pkg::ADDR_COUNT_LOW, 8'hFF);
    wr_reg(udt_pkg::ADDR_COUNT_HIGH, 8'hFF);
    wr_reg(udt_pkg::ADDR_CONTROL, 8'h24);
    repeat (6) @(posedge clk);
    rd_reg(udt_pkg::ADDR_IRQ_STATUS, 8'h00);
    rd_reg(udt_pkg::ADDR_COUNT_HIGH, 8'h00);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd_reg(udt_pkg::ADDR_CONTROL, 8'h00);
    rd_reg(udt_pkg::ADDR_COUNT_LOW, 8'h00);
    repeat (3) @(posedge clk);
    complete_run();
  end
endmodule

// ### hdl/udt_pkg.sv
package udt_pkg;
  // Register indices on the plain register port.
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_MODE = 4'h1;
  localparam logic [3:0] ADDR_RELOAD_LOW = 4'h2;
  localparam logic [3:0] ADDR_RELOAD_HIGH = 4'h3;
  localparam logic [3:0] ADDR_COUNT_LOW = 4'h4;
  localparam logic [3:0] ADDR_COUNT_HIGH = 4'h5;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h6;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h7;
  // Control register field positions, then the mode register up-down enable bit.
  localparam int BIT_CAPTURE_RELOAD_SELECT = 0;
  localparam int BIT_COUNT_SOURCE_SELECT = 1;
  localparam int BIT_RUN_CONTROL = 2;
  localparam int BIT_TRIGGER_PIN_ENABLE = 3;
  localparam int BIT_TX_BAUD_SELECT = 4;
  localparam int BIT_RX_BAUD_SELECT = 5;
  localparam int BIT_TRIGGER_FLAG = 6;
  localparam int BIT_OVERFLOW_FLAG = 7;
  localparam int BIT_UPDOWN_ENABLE = 0;
  // Interrupt status bits.
  localparam int IRQ_OVERFLOW = 0;
  localparam int IRQ_TRIGGER = 1;
  // Reset values.
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [1:0] IRQ_RESET = 2'h0;
  // Machine cycle of twelve oscillator periods, one per clk.
  localparam int MACHINE_CYCLE_CLKS = 12;
  localparam int BAUD_CYCLE_CLKS = 2;
endpackage

// ### hdl/udt_timer.sv
// Contract
// - Sixteen-bit count pair counts up or down per configuration and trigger pin.
// - Count-source select picks machine cycles (every second clock in baud mode) or external count pin falling edges.
// - Auto-reload, capture or baud mode chosen by select bits while running.
// - Capture mode counts up; enabled trigger falling edge copies count into reload.
// - Baud generator mode overflow never sets the overflow flag.
// - Baud mode with trigger enable: trigger falling edge raises the trigger flag.
//
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module udt_timer #(
  parameter int WIDTH = 16
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Register port.
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // Pins.
  input wire logic count_input_pin,
  input wire logic trigger_pin,
  // Serial port baud tick and interrupt.
  output logic baud_tick,
  output logic irq
);
  logic [7:0] ctrl;
  logic updown_enable;
  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] reload;
  logic [1:0] irq_mask;
  logic [3:0] presc;
  logic count_pin_q;
  logic trig_q;
  logic [WIDTH-1:0] next_count;

  wire run_control = ctrl[udt_pkg::BIT_RUN_CONTROL];
  wire capture_reload_select = ctrl[udt_pkg::BIT_CAPTURE_RELOAD_SELECT];
  wire count_source_select = ctrl[udt_pkg::BIT_COUNT_SOURCE_SELECT];
  wire trigger_pin_enable = ctrl[udt_pkg::BIT_TRIGGER_PIN_ENABLE];
  wire baud_mode = ctrl[udt_pkg::BIT_TX_BAUD_SELECT] | ctrl[udt_pkg::BIT_RX_BAUD_SELECT];
  wire capture_mode = ~baud_mode & capture_reload_select;
  wire reload_mode = ~baud_mode & ~capture_reload_select;
  wire [1:0] irq_status = {ctrl[udt_pkg::BIT_TRIGGER_FLAG], ctrl[udt_pkg::BIT_OVERFLOW_FLAG]};

  // Baud mode ticks every second clock, the other modes once per machine cycle.
  wire [3:0] presc_top = baud_mode ? 4'(udt_pkg::BAUD_CYCLE_CLKS - 1) : 4'(udt_pkg::MACHINE_CYCLE_CLKS - 1);
  wire int_tick = (presc >= presc_top);
  wire ext_tick = count_pin_q & ~count_input_pin;
  wire tick = run_control & (count_source_select ? ext_tick : int_tick);
  wire trig_fall = trig_q & ~trigger_pin & trigger_pin_enable;
  wire count_down = reload_mode & updown_enable & ~trigger_pin;
  wire up_wrap = (count == {WIDTH{1'b1}});
  wire down_wrap = (count == reload);
  wire wrap = tick & (count_down ? down_wrap : up_wrap);
  wire set_ovf = wrap & ~baud_mode;
  wire set_trg = trig_fall & (~reload_mode | ~updown_enable) & run_control;
  wire wr_ctrl = wr & (addr == udt_pkg::ADDR_CONTROL);
  wire wr_stat = wr & (addr == udt_pkg::ADDR_IRQ_STATUS);

  // Down counting wraps to all ones; up counting reloads in reload and baud modes.
  always_comb begin
    next_count = count;
    if (tick) begin
      if (count_down) begin
        next_count = down_wrap ? {WIDTH{1'b1}} : count - 1'b1;
      end else if (up_wrap & ~capture_mode) begin
        next_count = reload;
      end else begin
        next_count = count + 1'b1;
      end
    end
    if (reload_mode & trig_fall & ~updown_enable & run_control) begin
      next_count = reload;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      presc <= 4'h0;
      count_pin_q <= 1'b0;
      trig_q <= 1'b0;
    end else begin
      presc <= int_tick ? 4'h0 : presc + 4'h1;
      count_pin_q <= count_input_pin;
      trig_q <= trigger_pin;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= udt_pkg::COUNT_RESET;
    end else if (wr & (addr == udt_pkg::ADDR_COUNT_LOW)) begin
      count[7:0] <= wdata;
    end else if (wr & (addr == udt_pkg::ADDR_COUNT_HIGH)) begin
      count[15:8] <= wdata;
    end else begin
      count <= next_count;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reload <= udt_pkg::COUNT_RESET;
    end else if (capture_mode & trig_fall & run_control) begin
      reload <= count;
    end else if (wr & (addr == udt_pkg::ADDR_RELOAD_LOW)) begin
      reload[7:0] <= wdata;
    end else if (wr & (addr == udt_pkg::ADDR_RELOAD_HIGH)) begin
      reload[15:8] <= wdata;
    end
  end

  // Flags: hardware set wins over a software clear in the same cycle.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl <= udt_pkg::CONTROL_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl <= wdata;
      end else if (wr_stat) begin
        ctrl[udt_pkg::BIT_OVERFLOW_FLAG] <= ctrl[udt_pkg::BIT_OVERFLOW_FLAG] & ~wdata[udt_pkg::IRQ_OVERFLOW];
        ctrl[udt_pkg::BIT_TRIGGER_FLAG] <= ctrl[udt_pkg::BIT_TRIGGER_FLAG] & ~wdata[udt_pkg::IRQ_TRIGGER];
      end
      if (set_ovf) begin
        ctrl[udt_pkg::BIT_OVERFLOW_FLAG] <= 1'b1;
      end
      if (set_trg) begin
        ctrl[udt_pkg::BIT_TRIGGER_FLAG] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      updown_enable <= 1'b0;
      irq_mask <= udt_pkg::IRQ_RESET;
      rdata <= 8'h00;
      baud_tick <= 1'b0;
    end else begin
      if (wr & (addr == udt_pkg::ADDR_MODE)) begin
        updown_enable <= wdata[udt_pkg::BIT_UPDOWN_ENABLE];
      end
      if (wr & (addr == udt_pkg::ADDR_IRQ_MASK)) begin
        irq_mask <= wdata[1:0];
      end
      baud_tick <= wrap & baud_mode;
      rdata <= 8'h00;
      if (rd) begin
        if (addr == udt_pkg::ADDR_CONTROL) begin
          rdata <= ctrl;
        end else if (addr == udt_pkg::ADDR_MODE) begin
          rdata <= {7'h00, updown_enable};
        end else if (addr == udt_pkg::ADDR_RELOAD_LOW) begin
          rdata <= reload[7:0];
        end else if (addr == udt_pkg::ADDR_RELOAD_HIGH) begin
          rdata <= reload[15:8];
        end else if (addr == udt_pkg::ADDR_COUNT_LOW) begin
          rdata <= count[7:0];
        end else if (addr == udt_pkg::ADDR_COUNT_HIGH) begin
          rdata <= count[15:8];
        end else if (addr == udt_pkg::ADDR_IRQ_STATUS) begin
          rdata <= {6'h00, irq_status};
        end else if (addr == udt_pkg::ADDR_IRQ_MASK) begin
          rdata <= {6'h00, irq_mask};
        end
      end
    end
  end

  assign irq = |(irq_status & irq_mask);

  a_capture_copies: assert property (@(posedge clk) disable iff (rst)
    capture_mode && run_control && trig_fall && !wr |=> reload == $past(count))
    else $error("capture did not copy count");
  a_baud_no_ovf: assert property (@(posedge clk) disable iff (rst)
    baud_mode && !wr_ctrl |=> $past(ctrl[udt_pkg::BIT_OVERFLOW_FLAG]) || !ctrl[udt_pkg::BIT_OVERFLOW_FLAG])
    else $error("overflow flag set in baud mode");
  a_overflow_sets: assert property (@(posedge clk) disable iff (rst)
    set_ovf |=> ctrl[udt_pkg::BIT_OVERFLOW_FLAG])
    else $error("overflow flag not set");
  a_baud_trigger: assert property (@(posedge clk) disable iff (rst)
    baud_mode && run_control && trig_fall |=> ctrl[udt_pkg::BIT_TRIGGER_FLAG])
    else $error("trigger flag not raised in baud mode");
  a_stopped_holds: assert property (@(posedge clk) disable iff (rst)
    !run_control && !wr |=> count == $past(count))
    else $error("count moved while stopped");
  a_reload_wrap: assert property (@(posedge clk) disable iff (rst)
    reload_mode && tick && up_wrap && !count_down && !trig_fall && !wr |=> count == $past(reload))
    else $error("no reload on overflow");
  a_down_count: assert property (@(posedge clk) disable iff (rst)
    tick && count_down && !down_wrap && !wr |=> count == $past(count) - 16'h0001)
    else $error("down count wrong");
  a_ext_source: assert property (@(posedge clk) disable iff (rst)
    count_source_select && !ext_tick && !trig_fall && !wr |=> count == $past(count))
    else $error("count moved without a pin edge");
  a_up_count: assert property (@(posedge clk) disable iff (rst)
    tick && !count_down && !up_wrap && !trig_fall && !wr |=> count == $past(count) + 16'h0001)
    else $error("up count wrong");
  a_down_wrap: assert property (@(posedge clk) disable iff (rst)
    tick && count_down && down_wrap && !wr |=> &count && ctrl[udt_pkg::BIT_OVERFLOW_FLAG])
    else $error("down count did not wrap to all ones");
  a_capture_up: assert property (@(posedge clk) disable iff (rst)
    capture_mode && tick && !up_wrap && !wr |=> count == $past(count) + 16'h0001)
    else $error("capture mode did not count up");
  a_trigger_reload: assert property (@(posedge clk) disable iff (rst)
    reload_mode && run_control && trig_fall && !updown_enable && !wr |=> count == $past(reload))
    else $error("no reload on trigger edge");
  a_trigger_flag: assert property (@(posedge clk) disable iff (rst)
    reload_mode && run_control && trig_fall && !updown_enable |=> ctrl[udt_pkg::BIT_TRIGGER_FLAG])
    else $error("trigger flag not raised in reload mode");
  a_direction_pin: assert property (@(posedge clk) disable iff (rst)
    reload_mode && updown_enable && trig_fall && !tick && !wr |=> count == $past(count))
    else $error("trigger edge moved count in up-down mode");
  a_stopped_frozen: assert property (@(posedge clk) disable iff (rst)
    !run_control && !wr |=> ctrl == $past(ctrl))
    else $error("control or flags changed while stopped");
  a_baud_tick: assert property (@(posedge clk) disable iff (rst)
    baud_mode && wrap |=> baud_tick)
    else $error("baud tick missing after overflow");
endmodule
